//--- rtl/qsr_map.svh
`ifndef QSR_MAP_SVH
`define QSR_MAP_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define QSR_ADDR_W 8
`define QSR_DATA_W 32
`define QSR_LVL_W 6
`define QSR_EVT_W 7
`define QSR_FIFO_DEPTH 4
`define QSR_LEN_W 5

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define QSR_OFS_EVENT_MASK 8'h2C
`define QSR_OFS_MASKED_EVENTS 8'h30
`define QSR_OFS_RAW_EVENT_FLAGS 8'h34
`define QSR_OFS_TX_OVERFLOW_CLEAR 8'h38
`define QSR_OFS_RX_OVERFLOW_CLEAR 8'h3C
`define QSR_OFS_RX_UNDERFLOW_CLEAR 8'h40
`define QSR_OFS_CONTENTION_CLEAR 8'h44
`define QSR_OFS_COMBINED_EVENT_CLEAR 8'h48
`define QSR_OFS_DMA_HANDSHAKE_CONTROL 8'h4C
`define QSR_OFS_TX_DMA_WATERMARK 8'h50
`define QSR_OFS_RX_DMA_WATERMARK 8'h54
`define QSR_OFS_WINDOW_FIRST 8'h60
`define QSR_OFS_WINDOW_LAST 8'hDC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QSR_EVT_XIP_RX_OVERFLOW 6
`define QSR_EVT_CONTENTION 5
`define QSR_EVT_RX_FULL 4
`define QSR_EVT_RX_OVERFLOW 3
`define QSR_EVT_RX_UNDERFLOW 2
`define QSR_EVT_TX_OVERFLOW 1
`define QSR_EVT_TX_EMPTY 0
`define QSR_DMA_TX_EN_BIT 1
`define QSR_DMA_RX_EN_BIT 0

// ----------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------
`define QSR_RST_EVENT_MASK 7'h7F
`define QSR_RST_DMA_CTRL 2'h0
`define QSR_RST_WATERMARK 6'h00
`define QSR_RESP_OKAY 2'h0
`define QSR_RESP_SLVERR 2'h2

`endif

//--- rtl/qsr_pkg.sv
package qsr_pkg;

	// Seven event flags in register bit order, bit 6 first
	typedef struct packed {
		logic xip_rx_overflow;
		logic contention;
		logic rx_full;
		logic rx_overflow;
		logic rx_underflow;
		logic tx_overflow;
		logic tx_empty;
	} qsr_evt_t;

	// DMA handshake settings held by software
	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic [5:0] tx_watermark_level;
		logic [5:0] rx_watermark_level;
	} qsr_dma_cfg_t;

	// A frame moving between the window and a FIFO
	typedef struct packed {
		logic [31:0] fifo_window_word;
	} qsr_word_t;

endpackage

//--- rtl/qsr_fifo.sv
`timescale 1ns/100ps
module qsr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	wire logic push = in_valid & in_ready;
	wire logic pop = out_valid & out_ready;

	// Full and empty come straight from the occupancy count
	assign in_ready = (count_r != DEPTH[PW:0]);
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_ptr_r];

	always_ff @(posedge aclk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end
endmodule

//--- rtl/qsr_event_flags.sv
`timescale 1ns/100ps
module qsr_event_flags
	import qsr_pkg::*;
#(
	parameter int N = 7
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// One-cycle set and clear strobes per flag
	input wire logic [N-1:0] set,
	input wire logic [N-1:0] clr,
	// Sticky flags
	output logic [N-1:0] flags
);
	logic [N-1:0] flag_r;

	// ----------------------------------------------------------------
	// Sticky bits; a set in the clearing cycle is kept
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					flag_r[i] <= 1'b0;
				end else if (set[i]) begin
					flag_r[i] <= 1'b1;
				end else if (clr[i]) begin
					flag_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign flags = flag_r;
endmodule

//--- rtl/qsr_regs.sv
// Contract
// - Raw event register holds seven flags, bit 6 xip overflow to bit 0 tx empty.
// - Raw flags read 1 while their event stands, unmasked; bits 31:7 read zero.
// - Reading offset 0x38 clears the transmit overflow flag.
// - Reading offset 0x3C clears the receive overflow flag.
// - Reading offset 0x40 clears the receive underflow flag.
// - Reading offset 0x44 clears the contention flag.
// - Reading 0x48 clears tx overflow, rx overflow, rx underflow, contention only.
// - DMA control bit 1 enables transmit, bit 0 receive handshake; both reset off.
// - Offset 0x50 bits 5:0 hold the transmit watermark, reset zero.
// - Offset 0x54 bits 5:0 hold the receive watermark, reset zero.
// - Window covers 32 words from 0x60, stride 4, all one 32-bit FIFO port.
// - Window read pops receive FIFO, frame right-aligned, upper bits zero.
// - Masked status is raw AND mask; mask bits reset to all ones.
`timescale 1ns/100ps
`include "qsr_map.svh"
module qsr_regs
	import qsr_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [`QSR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`QSR_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [`QSR_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [`QSR_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Event sources from the protocol engine
	input wire logic tx_empty_raw,
	input wire logic rx_full_raw,
	input wire logic xip_rx_overflow_raw,
	input wire logic tx_overflow_evt,
	input wire logic rx_overflow_evt,
	input wire logic rx_underflow_evt,
	input wire logic contention_evt,
	// Transmit stream towards the transmit FIFO core
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [`QSR_DATA_W-1:0] tx_data,
	// Receive stream from the receive FIFO core
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [`QSR_DATA_W-1:0] rx_data,
	input wire logic [`QSR_LEN_W-1:0] frame_len_m1,
	// FIFO fill levels for the DMA handshake
	input wire logic [`QSR_LVL_W-1:0] tx_fifo_level,
	input wire logic [`QSR_LVL_W-1:0] rx_fifo_level,
	// DMA requests and event status
	output logic tx_dma_req,
	output logic rx_dma_req,
	output logic [`QSR_EVT_W-1:0] masked_events
);

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	function automatic logic in_window(input logic [`QSR_ADDR_W-1:0] a);
		in_window = (a[1:0] == 2'h0) && (a >= `QSR_OFS_WINDOW_FIRST) &&
			(a <= `QSR_OFS_WINDOW_LAST);
	endfunction

	function automatic logic is_mapped(input logic [`QSR_ADDR_W-1:0] a);
		case (a)
			`QSR_OFS_EVENT_MASK, `QSR_OFS_MASKED_EVENTS,
			`QSR_OFS_RAW_EVENT_FLAGS, `QSR_OFS_TX_OVERFLOW_CLEAR,
			`QSR_OFS_RX_OVERFLOW_CLEAR, `QSR_OFS_RX_UNDERFLOW_CLEAR,
			`QSR_OFS_CONTENTION_CLEAR, `QSR_OFS_COMBINED_EVENT_CLEAR,
			`QSR_OFS_DMA_HANDSHAKE_CONTROL, `QSR_OFS_TX_DMA_WATERMARK,
			`QSR_OFS_RX_DMA_WATERMARK: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = in_window(a);
			end
		endcase
	endfunction

	// Keep only the bits of the current frame length
	function automatic logic [`QSR_DATA_W-1:0] right_align(
		input logic [`QSR_DATA_W-1:0] d,
		input logic [`QSR_LEN_W-1:0] len_m1
	);
		right_align = d & ({`QSR_DATA_W{1'b1}} >>
			(`QSR_DATA_W - 1 - int'(len_m1)));
	endfunction

	// ----------------------------------------------------------------
	// Channel state, settings and handshakes
	// ----------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [`QSR_ADDR_W-1:0] awaddr_r;
	logic [`QSR_DATA_W-1:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [`QSR_DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic [`QSR_EVT_W-1:0] mask_r;
	qsr_dma_cfg_t dma_cfg_r;

	wire logic aw_take = s_axi_awvalid & s_axi_awready;
	wire logic w_take = s_axi_wvalid & s_axi_wready;
	wire logic ar_take = s_axi_arvalid & s_axi_arready;

	assign s_axi_awready = ~aw_held_r;
	assign s_axi_wready = ~w_held_r;
	// One read in flight; a new address waits for the data to go
	assign s_axi_arready = ~rvalid_r;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire logic wr_win = in_window(awaddr_r);
	wire logic wr_mapped = is_mapped(awaddr_r);
	wire logic fifo_in_ready;
	// A window write stalls while the transmit buffer is full
	wire logic wr_go = aw_held_r & w_held_r & ~bvalid_r &
		(~wr_win | fifo_in_ready);
	wire logic wr_low = wr_go & wstrb_r[0];
	wire logic wr_mask = wr_low && (awaddr_r == `QSR_OFS_EVENT_MASK);
	wire logic wr_dma = wr_low &&
		(awaddr_r == `QSR_OFS_DMA_HANDSHAKE_CONTROL);
	wire logic wr_txwm = wr_low && (awaddr_r == `QSR_OFS_TX_DMA_WATERMARK);
	wire logic wr_rxwm = wr_low && (awaddr_r == `QSR_OFS_RX_DMA_WATERMARK);
	wire logic wr_push = wr_go & wr_win;

	// ----------------------------------------------------------------
	// Read decode and clear-on-read side effects
	// ----------------------------------------------------------------
	wire logic rd_win = ar_take & in_window(s_axi_araddr);
	wire logic rd_mapped = is_mapped(s_axi_araddr);
	wire logic rd_tx_ovf = ar_take &&
		(s_axi_araddr == `QSR_OFS_TX_OVERFLOW_CLEAR);
	wire logic rd_rx_ovf = ar_take &&
		(s_axi_araddr == `QSR_OFS_RX_OVERFLOW_CLEAR);
	wire logic rd_rx_unf = ar_take &&
		(s_axi_araddr == `QSR_OFS_RX_UNDERFLOW_CLEAR);
	wire logic rd_cont = ar_take &&
		(s_axi_araddr == `QSR_OFS_CONTENTION_CLEAR);
	wire logic rd_all = ar_take &&
		(s_axi_araddr == `QSR_OFS_COMBINED_EVENT_CLEAR);

	// Window read on an empty receive side counts as underflow
	wire logic rd_empty = rd_win & ~rx_valid;
	assign rx_ready = rd_win;

	// ----------------------------------------------------------------
	// Sticky event flags
	// ----------------------------------------------------------------
	logic [`QSR_EVT_W-1:0] evt_set;
	logic [`QSR_EVT_W-1:0] evt_clr;
	logic [`QSR_EVT_W-1:0] evt_sticky;
	qsr_evt_t raw;

	always_comb begin
		evt_set = '0;
		evt_clr = '0;
		evt_set[`QSR_EVT_TX_OVERFLOW] = tx_overflow_evt;
		evt_set[`QSR_EVT_RX_OVERFLOW] = rx_overflow_evt;
		evt_set[`QSR_EVT_RX_UNDERFLOW] = rx_underflow_evt | rd_empty;
		evt_set[`QSR_EVT_CONTENTION] = contention_evt;
		evt_clr[`QSR_EVT_TX_OVERFLOW] = rd_tx_ovf | rd_all;
		evt_clr[`QSR_EVT_RX_OVERFLOW] = rd_rx_ovf | rd_all;
		evt_clr[`QSR_EVT_RX_UNDERFLOW] = rd_rx_unf | rd_all;
		evt_clr[`QSR_EVT_CONTENTION] = rd_cont | rd_all;
	end

	qsr_event_flags #(
		.N(`QSR_EVT_W)
	) u_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(evt_set),
		.clr(evt_clr),
		.flags(evt_sticky)
	);

	// Level events follow their source; cleared events stay sticky
	always_comb begin
		raw = qsr_evt_t'(evt_sticky);
		raw.tx_empty = tx_empty_raw;
		raw.rx_full = rx_full_raw;
		raw.xip_rx_overflow = xip_rx_overflow_raw;
	end

	assign masked_events = raw & mask_r;

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	logic [`QSR_DATA_W-1:0] rd_sel;

	always_comb begin
		rd_sel = '0;
		case (s_axi_araddr)
			`QSR_OFS_EVENT_MASK: begin
				rd_sel[`QSR_EVT_W-1:0] = mask_r;
			end
			`QSR_OFS_MASKED_EVENTS: begin
				rd_sel[`QSR_EVT_W-1:0] = masked_events;
			end
			`QSR_OFS_RAW_EVENT_FLAGS: begin
				rd_sel[`QSR_EVT_W-1:0] = raw;
			end
			`QSR_OFS_DMA_HANDSHAKE_CONTROL: begin
				rd_sel[`QSR_DMA_TX_EN_BIT] = dma_cfg_r.tx_en;
				rd_sel[`QSR_DMA_RX_EN_BIT] = dma_cfg_r.rx_en;
			end
			`QSR_OFS_TX_DMA_WATERMARK: begin
				rd_sel[`QSR_LVL_W-1:0] = dma_cfg_r.tx_watermark_level;
			end
			`QSR_OFS_RX_DMA_WATERMARK: begin
				rd_sel[`QSR_LVL_W-1:0] = dma_cfg_r.rx_watermark_level;
			end
			default: begin
				// Clear registers read zero; empty window reads zero
				if (in_window(s_axi_araddr) && rx_valid) begin
					rd_sel = right_align(rx_data, frame_len_m1);
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Transmit buffer and DMA requests
	// ----------------------------------------------------------------
	qsr_fifo #(
		.WIDTH(`QSR_DATA_W),
		.DEPTH(`QSR_FIFO_DEPTH)
	) u_tx_buf (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(wr_push),
		.in_ready(fifo_in_ready),
		.in_data(wdata_r),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);
	assign tx_dma_req = dma_cfg_r.tx_en &&
		(tx_fifo_level <= dma_cfg_r.tx_watermark_level);
	assign rx_dma_req = dma_cfg_r.rx_en &&
		(rx_fifo_level > dma_cfg_r.rx_watermark_level);

	// ----------------------------------------------------------------
	// Write channel registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end else if (aw_take) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (w_take) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `QSR_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? `QSR_RESP_OKAY : `QSR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Settings; only the low byte lane carries fields
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r <= `QSR_RST_EVENT_MASK;
		end else if (wr_mask) begin
			mask_r <= wdata_r[`QSR_EVT_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{dma_cfg_r.tx_en, dma_cfg_r.rx_en} <= `QSR_RST_DMA_CTRL;
		end else if (wr_dma) begin
			dma_cfg_r.tx_en <= wdata_r[`QSR_DMA_TX_EN_BIT];
			dma_cfg_r.rx_en <= wdata_r[`QSR_DMA_RX_EN_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_cfg_r.tx_watermark_level <= `QSR_RST_WATERMARK;
		end else if (wr_txwm) begin
			dma_cfg_r.tx_watermark_level <= wdata_r[`QSR_LVL_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_cfg_r.rx_watermark_level <= `QSR_RST_WATERMARK;
		end else if (wr_rxwm) begin
			dma_cfg_r.rx_watermark_level <= wdata_r[`QSR_LVL_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read channel registers and bus outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `QSR_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_sel;
			rresp_r <= rd_mapped ? `QSR_RESP_OKAY : `QSR_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule

//--- test/qsr_regs_props.sv
`timescale 1ns/100ps
`include "qsr_map.svh"
module qsr_regs_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [`QSR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [`QSR_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Streams and status
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [`QSR_DATA_W-1:0] tx_data,
	input wire logic rx_ready,
	input wire logic [`QSR_LVL_W-1:0] rx_fifo_level,
	input wire logic rx_dma_req,
	input wire logic [`QSR_EVT_W-1:0] masked_events,
	input wire logic tx_empty_raw,
	input wire logic rx_full_raw,
	input wire logic xip_rx_overflow_raw
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& !s_axi_bvalid && s_axi_awaddr < 8'h60 |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	ar_block_a: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answer pending");
	rx_pop_a: assert property (
		rx_ready |-> s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid)
		else $error("pop without a read");
	tx_hold_a: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("transmit word lost");
	mask_gate_a: assert property (
		!(masked_events[6] && !xip_rx_overflow_raw)
		&& !(masked_events[4] && !rx_full_raw)
		&& !(masked_events[0] && !tx_empty_raw))
		else $error("masked flag without raw flag");
	rx_dma_a: assert property (
		rx_dma_req |-> rx_fifo_level != 6'h00)
		else $error("receive request at empty level");
endmodule

bind qsr_regs qsr_regs_props chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_valid,
	.tx_ready, .tx_data, .rx_ready, .rx_fifo_level, .rx_dma_req,
	.masked_events, .tx_empty_raw, .rx_full_raw, .xip_rx_overflow_raw);

//--- test/qsr_far_end.sv
`timescale 1ns/100ps
module qsr_far_end (
	// Clock, reset and bench controls
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic ld_valid,
	input wire logic [31:0] ld_word,
	// Transmit stream sink
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [31:0] tx_data,
	// Receive stream source
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [31:0] rx_data
);
	logic [31:0] txq[$];
	logic [31:0] rxq[$];

	// A stalled sink lets the design's buffer fill up
	assign tx_ready = !stall;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rxq.delete();
			rx_valid <= 1'b0;
			rx_data <= 32'h5A5A_5A5A;
		end else begin
			if (tx_valid && tx_ready)
				txq.push_back(tx_data);
			if (rx_ready && rx_valid)
				void'(rxq.pop_front());
			if (ld_valid)
				rxq.push_back(ld_word);
			rx_valid <= rxq.size() != 0;
			// An empty source inverts its data word every cycle
			rx_data <= (rxq.size() != 0) ? rxq[0] : ~rx_data;
		end
	end
endmodule

//--- test/quad_serial_irq_dma_data_regs_test.sv
`timescale 1ns/100ps
module quad_serial_irq_dma_data_regs_test;
	logic aclk = 0, aresetn = 0, stall = 0, ld_valid = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, ld_word = 0, s_axi_rdata, tx_data, rx_data;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_valid, tx_ready, rx_valid, rx_ready;
	logic tx_empty_raw = 0, rx_full_raw = 0, xip_rx_overflow_raw = 0;
	logic tx_overflow_evt = 0, rx_overflow_evt = 0;
	logic rx_underflow_evt = 0, contention_evt = 0;
	logic [4:0] frame_len_m1 = 5'h1F;
	logic [5:0] tx_fifo_level = 0, rx_fifo_level = 0;
	logic tx_dma_req, rx_dma_req;
	logic [6:0] masked_events;
	logic [31:0] d;
	logic [7:0] ca[5] = '{8'h38, 8'h3C, 8'h40, 8'h44, 8'h48};
	logic [31:0] cm[5] = '{32'h02, 32'h08, 32'h04, 32'h20, 32'h2E};
	int error_cnt = 0, samples_checked = 0, cyc = 0;

	qsr_regs uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_empty_raw, .rx_full_raw, .xip_rx_overflow_raw,
		.tx_overflow_evt, .rx_overflow_evt, .rx_underflow_evt,
		.contention_evt, .tx_valid, .tx_ready, .tx_data, .rx_valid,
		.rx_ready, .rx_data, .frame_len_m1, .tx_fifo_level, .rx_fifo_level,
		.tx_dma_req, .rx_dma_req, .masked_events);
	qsr_far_end far (.aclk, .aresetn, .stall, .ld_valid, .ld_word,
		.tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data);

	// ------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------
	always #4 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done;
		$display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	// ------------------------------------------------------------
	// Bus tasks, entered just after a rising edge
	// ------------------------------------------------------------
	// Ready is looked at on the falling edge, where it has settled
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic ok_aw, ok_w, ok_b;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		ok_b = 0;
		while (!ok_b) begin
			@(negedge aclk);
			ok_aw = s_axi_awvalid && s_axi_awready;
			ok_w = s_axi_wvalid && s_axi_wready;
			ok_b = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ok_aw) s_axi_awvalid <= 1'b0;
			if (ok_w) s_axi_wvalid <= 1'b0;
			// Ready follows valid by a cycle, so the hold rules get used
			s_axi_bready <= s_axi_bvalid && !ok_b;
		end
		chk({30'h0, er}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ok_ar, ok_r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		ok_r = 0;
		while (!ok_r) begin
			@(negedge aclk);
			ok_ar = s_axi_arvalid && s_axi_arready;
			ok_r = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ok_ar) s_axi_arvalid <= 1'b0;
			s_axi_rready <= s_axi_rvalid && !ok_r;
		end
		chk(e, d);
		chk({30'h0, er}, {30'h0, r});
	endtask

	task automatic dma(input logic [5:0] t, input logic [5:0] rl,
		input logic et, input logic er);
		tx_fifo_level <= t;
		rx_fifo_level <= rl;
		@(negedge aclk);
		chk({31'h0, et}, {31'h0, tx_dma_req});
		chk({31'h0, er}, {31'h0, rx_dma_req});
		@(posedge aclk);
	endtask

	task automatic pulse;
		{tx_overflow_evt, rx_overflow_evt} <= 2'b11;
		{rx_underflow_evt, contention_evt} <= 2'b11;
		@(posedge aclk);
		{tx_overflow_evt, rx_overflow_evt} <= 2'b00;
		{rx_underflow_evt, contention_evt} <= 2'b00;
		@(posedge aclk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h4C, 32'h0, 2'h0);
		rd(8'h50, 32'h0, 2'h0);
		rd(8'h54, 32'h0, 2'h0);
		rd(8'h34, 32'h0, 2'h0);
		rd(8'h2C, 32'h7F, 2'h0);
		wr(8'h4C, 32'hFFFF_FFFF, 2'h0);
		wr(8'h50, 32'hFFFF_FFC2, 2'h0);
		wr(8'h54, 32'h0000_0041, 2'h0);
		rd(8'h4C, 32'h3, 2'h0);
		rd(8'h50, 32'h2, 2'h0);
		rd(8'h54, 32'h1, 2'h0);
		dma(6'h02, 6'h01, 1'b1, 1'b0);
		dma(6'h03, 6'h02, 1'b0, 1'b1);
		wr(8'h4C, 32'h2, 2'h0);
		dma(6'h00, 6'h3F, 1'b1, 1'b0);
		wr(8'h4C, 32'h1, 2'h0);
		dma(6'h00, 6'h3F, 1'b0, 1'b1);
		// Live levels must survive every clear
		tx_empty_raw <= 1'b1;
		xip_rx_overflow_raw <= 1'b1;
		pulse();
		rd(8'h34, 32'h6F, 2'h0);
		for (int i = 0; i < 5; i++) begin
			pulse();
			rd(ca[i], 32'h0, 2'h0);
			rd(8'h34, 32'h6F & ~cm[i], 2'h0);
		end
		rx_full_raw <= 1'b1;
		tx_empty_raw <= 1'b0;
		wr(8'h2C, 32'h11, 2'h0);
		rd(8'h34, 32'h50, 2'h0);
		chk(32'h10, {25'h0, masked_events});
		rd(8'h30, 32'h10, 2'h0);
		rd(8'h58, 32'h0, 2'h2);
		rd(8'h62, 32'h0, 2'h2);
		wr(8'h5C, 32'h1, 2'h2);
		// Fill the buffer against a stalled sink
		stall <= 1'b1;
		for (int i = 0; i < 4; i++)
			wr(8'h60 + 8'(i * 28), 32'hA0 + i, 2'h0);
		fork
			wr(8'hDC, 32'hA4, 2'h0);
			begin
				repeat (20) @(negedge aclk);
				chk(32'h0, {31'h0, s_axi_bvalid});
				@(posedge aclk);
				stall <= 1'b0;
			end
		join
		repeat (10) @(posedge aclk);
		for (int i = 0; i < 5; i++)
			chk(32'hA0 + i, far.txq[i]);
		ld_valid <= 1'b1;
		ld_word <= 32'hFFFF_A5C3;
		@(posedge aclk);
		ld_word <= 32'h1234_5678;
		@(posedge aclk);
		ld_valid <= 1'b0;
		frame_len_m1 <= 5'h07;
		rd(8'h60, 32'hC3, 2'h0);
		frame_len_m1 <= 5'h1F;
		rd(8'hDC, 32'h1234_5678, 2'h0);
		rd(8'h80, 32'h0, 2'h0);
		rd(8'h34, 32'h54, 2'h0);
		test_done();
	end
endmodule
